// ---- tecx_channel.sv ----
// Purpose: one timer: synchronises its clock and direction pins, counts
// Assumes: pins are asynchronous to mclk
// Notes:   quadrature mode counts each single phase transition, not both phases changing in one cycle
`timescale 1ns/10ps
module tecx_channel
	import tecx_pkg::*;
(
	// clock and control
	input  wire logic                        mclk,
	input  wire logic                        sys_rst,
	input  wire logic                        clk_en,
	input  wire logic                        quad_mode,
	// external pins
	input  wire logic                        ext_clock,
	input  wire logic                        ext_direction,
	// results
	output logic                             clock_sync,
	output logic                             step,
	output logic [TECX_COUNT_WIDTH-1:0]      count
);
	logic [1:0] sync_clk;
	logic [1:0] sync_dir;
	logic       last_clk;
	logic       last_dir;
	logic       clk_edge;
	logic       dir_edge;
	logic       quad_up;
	logic       next_up;
	logic       next_step;
	logic [TECX_COUNT_WIDTH-1:0] next_count;

	// -----------------------------------------------------------------
	// pin synchronisers
	// -----------------------------------------------------------------
	// two flops per pin; only sync_x[1] is read by logic
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sync_clk <= TECX_SYNC_RESET;
			sync_dir <= TECX_SYNC_RESET;
			last_clk <= 1'b0;
			last_dir <= 1'b0;
		end else if (clk_en) begin
			sync_clk <= {sync_clk[0], ext_clock};
			sync_dir <= {sync_dir[0], ext_direction};
			last_clk <= sync_clk[1];
			last_dir <= sync_dir[1];
		end
	end

	// -----------------------------------------------------------------
	// edge decode
	// -----------------------------------------------------------------
	// either edge of the clock pin counts once
	assign clk_edge  = sync_clk[1] ^ last_clk;
	assign dir_edge  = sync_dir[1] ^ last_dir;
	// quadrature: up when phase a leads phase b
	assign quad_up   = (sync_clk[1] ^ last_dir);
	assign next_step = quad_mode ? (clk_edge ^ dir_edge) : clk_edge;
	// clock/direction mode: direction pin high counts up, low counts down; quadrature mode uses quad_up
	assign next_up   = quad_mode ? quad_up : sync_dir[1];
	assign next_count = next_up ? count + TECX_STEP_ONE
	                            : count - TECX_STEP_ONE;

	// counter register
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			count <= TECX_COUNT_RESET;
			step  <= 1'b0;
		end else if (clk_en) begin
			step <= next_step;
			if (next_step) begin
				count <= next_count;
			end
		end
	end

	assign clock_sync = sync_clk[1];

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	a_one_step_edge: assert property (@(posedge mclk)
		disable iff (sys_rst)
		clk_en && !quad_mode && clk_edge |=> count != $past(count))
		else $error("count missed a clock edge");
	a_no_edge_hold: assert property (@(posedge mclk)
		disable iff (sys_rst)
		clk_en && !next_step |=> $stable(count))
		else $error("count moved without an edge");
	a_dir_up_count: assert property (@(posedge mclk)
		disable iff (sys_rst)
		clk_en && !quad_mode && clk_edge && sync_dir[1]
		|=> count == $past(count) + TECX_STEP_ONE)
		else $error("count did not rise with direction high");
	a_dir_down_count: assert property (@(posedge mclk)
		disable iff (sys_rst)
		clk_en && !quad_mode && clk_edge && !sync_dir[1]
		|=> count == $past(count) - TECX_STEP_ONE)
		else $error("count did not fall with direction low");
	a_quad_up_step: assert property (@(posedge mclk)
		disable iff (sys_rst)
		clk_en && quad_mode && clk_edge && !dir_edge && quad_up
		|=> count == $past(count) + TECX_STEP_ONE)
		else $error("quadrature forward step wrong");
	a_quad_dir_step: assert property (@(posedge mclk)
		disable iff (sys_rst)
		clk_en && quad_mode && dir_edge && !clk_edge
		|=> count != $past(count))
		else $error("quadrature phase b edge not counted");
	a_quad_glitch_hold: assert property (@(posedge mclk)
		disable iff (sys_rst)
		clk_en && quad_mode && dir_edge && clk_edge |=> $stable(count))
		else $error("double phase change counted");
	a_freeze_hold: assert property (@(posedge mclk)
		disable iff (sys_rst)
		!clk_en |=> $stable(count) && $stable(step))
		else $error("state moved while disabled");
	c_count_up: cover property (@(posedge mclk) clk_edge && sync_dir[1]);
	c_count_down: cover property (@(posedge mclk) clk_edge && !sync_dir[1]);
	c_quad_step: cover property (@(posedge mclk) quad_mode && dir_edge);
endmodule // tecx_channel

// ---- tecx_pkg.sv ----
// Purpose: shared constants for the external timer count-input block
// Assumes: one 25 MHz system clock samples all external pins
// Notes:   timers are 16 bits wide
package tecx_pkg;
	localparam int          TECX_COUNT_WIDTH = 16;
	localparam logic [15:0] TECX_COUNT_RESET = 16'h0000;
	localparam logic [1:0]  TECX_SYNC_RESET  = 2'h0;
	localparam logic [15:0] TECX_STEP_ONE    = 16'h0001;
	localparam real         TECX_CLOCK_MHZ   = 25.0;
	// counting modes selected by the control inputs
	typedef enum logic {
		tecx_mode_dir_type_clkdir,
		tecx_mode_dir_type_quad
	} tecx_mode_type;
endpackage

// ---- tecx_pulse_src.sv ----
// Purpose: pulse and encoder source driving the four timer pins
// Assumes: pins change just after a falling mclk edge
// Notes:   each change is held for at least hold cycles
`timescale 1ns/10ps
module tecx_pulse_src (
	// clock
	input  wire logic mclk,
	// pins
	output logic      timer_a_ext_clock,
	output logic      timer_a_ext_direction,
	output logic      timer_b_ext_clock,
	output logic      timer_b_ext_direction
);
	// -----------------------------------------------------------
	// pin control
	// -----------------------------------------------------------
	// all pins low from time zero
	initial begin
		{timer_a_ext_clock, timer_a_ext_direction} = 2'h0;
		{timer_b_ext_clock, timer_b_ext_direction} = 2'h0;
	end
	// toggle one pin, then hold it
	task automatic move(input int pin, input int hold);
		@(negedge mclk);
		case (pin)
			0: timer_a_ext_clock = ~timer_a_ext_clock;
			1: timer_a_ext_direction = ~timer_a_ext_direction;
			2: timer_b_ext_clock = ~timer_b_ext_clock;
			default: timer_b_ext_direction = ~timer_b_ext_direction;
		endcase
		repeat (hold) @(negedge mclk);
	endtask
endmodule // tecx_pulse_src

// ---- tecx_top.sv ----
// Purpose: external count inputs for two up/down timers
// Assumes: all pins asynchronous; control inputs come from mclk logic
// Notes:   timer a clock may feed the baud generator
`timescale 1ns/10ps
module tecx_top
	import tecx_pkg::*;
(
	// clock and reset
	input  wire logic                        mclk,
	input  wire logic                        sys_rst,
	input  wire logic                        clk_en,
	// mode control from the core
	input  wire logic                        timer_a_quad_mode,
	input  wire logic                        timer_b_quad_mode,
	input  wire logic                        baud_use_ext_clock,
	input  wire logic                        baud_int_clock,
	// external pins
	input  wire logic                        timer_a_ext_clock,
	input  wire logic                        timer_a_ext_direction,
	input  wire logic                        timer_b_ext_clock,
	input  wire logic                        timer_b_ext_direction,
	// timer results
	output logic [TECX_COUNT_WIDTH-1:0]      timer_a_count,
	output logic [TECX_COUNT_WIDTH-1:0]      timer_b_count,
	output logic                             timer_a_step,
	output logic                             timer_b_step,
	// baud generator clock source
	output logic                             baud_clock
);
	logic a_clock_sync;
	logic next_baud_clock;

	// -----------------------------------------------------------------
	// timer channels
	// -----------------------------------------------------------------
	// timer a
	tecx_channel u_timer_a (
		.mclk          (mclk),
		.sys_rst       (sys_rst),
		.clk_en        (clk_en),
		.quad_mode     (timer_a_quad_mode),
		.ext_clock     (timer_a_ext_clock),
		.ext_direction (timer_a_ext_direction),
		.clock_sync    (a_clock_sync),
		.step          (timer_a_step),
		.count         (timer_a_count)
	);

	// timer b
	tecx_channel u_timer_b (
		.mclk          (mclk),
		.sys_rst       (sys_rst),
		.clk_en        (clk_en),
		.quad_mode     (timer_b_quad_mode),
		.ext_clock     (timer_b_ext_clock),
		.ext_direction (timer_b_ext_direction),
		.clock_sync    (),
		.step          (timer_b_step),
		.count         (timer_b_count)
	);

	// -----------------------------------------------------------------
	// baud clock selection
	// -----------------------------------------------------------------
	// pick synchronised pin or internal source
	assign next_baud_clock = baud_use_ext_clock ? a_clock_sync
	                                            : baud_int_clock;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			baud_clock <= 1'b0;
		end else if (clk_en) begin
			baud_clock <= next_baud_clock;
		end
	end

	a_baud_ext_sel: assert property (@(posedge mclk)
		disable iff (sys_rst)
		clk_en && baud_use_ext_clock |=> baud_clock == $past(a_clock_sync))
		else $error("baud clock not following timer a pin");
	a_baud_int_sel: assert property (@(posedge mclk)
		disable iff (sys_rst)
		clk_en && !baud_use_ext_clock
		|=> baud_clock == $past(baud_int_clock))
		else $error("baud clock not following internal source");
	c_baud_ext: cover property (@(posedge mclk) baud_use_ext_clock && baud_clock);
	c_both_step: cover property (@(posedge mclk) timer_a_step && timer_b_step);
endmodule // tecx_top

// ---- tecx_top_test.sv ----
// Purpose: self-checking bench for the timer count inputs
// Assumes: clk_en dropped now and then while the pins are idle
// Notes:   expected counts queued by the driver, popped on each step
`timescale 1ns/10ps
module tecx_top_test;
	import tecx_pkg::*;
	logic        mclk, sys_rst, qa, qb, use_ext, int_clk, baud;
	logic        a_clk, a_dir, b_clk, b_dir, a_step, b_step, c, d, up, en;
	logic [15:0] a_cnt, b_cnt, exp_a, exp_b;
	logic [15:0] qa_q[$], qb_q[$];
	int          n_fail, compares, seed, pin, i, m;
	// -----------------------------------------------------------
	// instances
	// -----------------------------------------------------------
	tecx_pulse_src u_src (.mclk(mclk), .timer_a_ext_clock(a_clk),
		.timer_a_ext_direction(a_dir), .timer_b_ext_clock(b_clk),
		.timer_b_ext_direction(b_dir));
	tecx_top u_dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(en),
		.timer_a_quad_mode(qa), .timer_b_quad_mode(qb),
		.baud_use_ext_clock(use_ext), .baud_int_clock(int_clk),
		.timer_a_ext_clock(a_clk), .timer_a_ext_direction(a_dir),
		.timer_b_ext_clock(b_clk), .timer_b_ext_direction(b_dir),
		.timer_a_count(a_cnt), .timer_b_count(b_cnt),
		.timer_a_step(a_step), .timer_b_step(b_step), .baud_clock(baud));
	// -----------------------------------------------------------
	// helpers
	// -----------------------------------------------------------
	task automatic check(input string nm, input logic [15:0] e, g);
		compares++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask
	task automatic summarize();
		if (n_fail == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// clock, 40 ns period
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// watchdog
	initial begin
		#400000;
		n_fail++;
		summarize();
	end
	// step monitor pops the oldest expected count
	always @(negedge mclk) begin
		if (a_step === 1'b1) begin
			if (qa_q.size() == 0) check("timer_a_step", 16'h0, 16'h1);
			else check("timer_a_count", qa_q.pop_front(), a_cnt);
		end
		if (b_step === 1'b1) begin
			if (qb_q.size() == 0) check("timer_b_step", 16'h0, 16'h1);
			else check("timer_b_count", qb_q.pop_front(), b_cnt);
		end
	end
	// -----------------------------------------------------------
	// main sequence: every mode pair, random pin moves
	// -----------------------------------------------------------
	initial begin
		seed = 32'h35dbb88a;
		sys_rst = 1'b1;
		en = 1'b1;
		{qa, qb, use_ext, int_clk} = 4'h0;
		exp_a = 16'h0000;
		exp_b = 16'h0000;
		repeat (4) @(negedge mclk);
		sys_rst = 1'b0;
		for (m = 0; m < 4; m++) begin
			{qb, qa} = m[1:0];
			for (i = 0; i < 40; i++) begin
				pin = $unsigned($random(seed)) % 4;
				use_ext = $random(seed);
				int_clk = $random(seed);
				{c, d} = (pin < 2) ? {a_clk, a_dir} : {b_clk, b_dir};
				// clock edge: dir level, or quad phase; dir edge: quad only
				up = pin[0] ? (c == ~d) : (((pin < 2) ? qa : qb) ? ~c ^ d : d);
				if (!pin[0] || ((pin < 2) ? qa : qb)) begin
					if (pin < 2) begin
						exp_a = exp_a + (up ? 16'h0001 : 16'hffff);
						qa_q.push_back(exp_a);
					end else begin
						exp_b = exp_b + (up ? 16'h0001 : 16'hffff);
						qb_q.push_back(exp_b);
					end
				end
				u_src.move(pin, 4 + $unsigned($random(seed)) % 4);
				check("baud_clock", {15'h0, use_ext ? a_clk : int_clk}, {15'h0, baud});
				// freeze a few cycles with pins idle: counts must hold
				if (i % 8 == 7) begin
					en = 1'b0;
					repeat (3) @(negedge mclk);
					check("timer_a_count", exp_a, a_cnt);
					check("timer_b_count", exp_b, b_cnt);
					en = 1'b1;
					@(negedge mclk);
				end
			end
		end
		repeat (8) @(negedge mclk);
		check("pending_steps", 16'h0, 16'(qa_q.size() + qb_q.size()));
		check("timer_a_count", exp_a, a_cnt);
		check("timer_b_count", exp_b, b_cnt);
		summarize();
	end
endmodule // tecx_top_test
